// ### logic/dum_top.sv
/*
 Dual modem serial port, device side: main port with flow control and
 modem lines, auxiliary port sharing the modem pins, rx buffer FIFO and
 a plain register port. Assumes pins are asynchronous to sys_clk.
*/
// Overview of operation
// - host drives TXD in, module drives RXD
// - module drives CTS, samples host RTS
// - default role: DTR in; DSR, DCD, RI out
// - low level is zero or ON
// - module is the DCE end
// - power-up main port in command mode
// - main port defaults to 115200 baud
// - main port defaults to 8N1, stop bits configurable
// - main hardware flow control on at power-up
// - multiplexing off until explicitly enabled
// - aux port off; takes modem pins exclusively
// - aux: DCD data out, DTR in, RI/DSR flow
// - aux enable restores flow control, 115200, 8N1
// - multiplexing only on the main port
// - mux frames tagged for virtual channels
`timescale 1ns/1ps
`include "dum_defs.svh"

module dum_fifo #(
   parameter int W = 10,
   parameter int D = 16
) (
   // clock and reset
   input  wire logic         sys_clk,
   input  wire logic         rst,
   // fill side
   input  wire logic [W-1:0] in_data,
   input  wire logic         in_valid,
   output logic              in_ready,
   // drain side
   output logic [W-1:0]      out_data,
   output logic              out_valid,
   input  wire logic         out_ready
);
   localparam int AW = $clog2(D);

   logic [W-1:0] mem_r [D];
   logic [AW-1:0] wp_r;
   logic [AW-1:0] rp_r;
   logic [AW:0]   cnt_r;
   wire           push = in_valid && in_ready;
   wire           pop  = out_valid && out_ready;

   assign in_ready  = (cnt_r != (AW+1)'(D));
   assign out_valid = (cnt_r != '0);
   assign out_data  = mem_r[rp_r];

   always_ff @(posedge sys_clk) begin
      if (push) begin
         mem_r[wp_r] <= in_data;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         wp_r  <= '0;
         rp_r  <= '0;
         cnt_r <= '0;
      end else begin
         wp_r  <= push ? wp_r + 1'b1 : wp_r;
         rp_r  <= pop ? rp_r + 1'b1 : rp_r;
         cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
      end
   end
endmodule : dum_fifo

module dum_uart
   import dum_pkg::*;
(
   // clock and reset
   input  wire logic       sys_clk,
   input  wire logic       rst,
   // line configuration
   input  wire dum_cfg_t   cfg,
   // transmit request
   input  wire logic [7:0] tx_data,
   input  wire logic       tx_valid,
   output logic            tx_ready,
   output logic            tx_busy,
   // peer flow state, 1 = peer may receive
   input  wire logic       peer_on,
   // serial lines, already synchronised
   output logic            txd,
   input  wire logic       rxd,
   // receive result
   output logic [7:0]      rx_data,
   output logic            rx_valid,
   output logic            rx_ferr
);
   dum_st_t     ts_r, ts_nxt, rs_r, rs_nxt;
   logic [16:0] tc_r, tc_nxt, rc_r, rc_nxt;
   logic [2:0]  tb_r, tb_nxt, rb_r, rb_nxt;
   logic [7:0]  tsh_r, tsh_nxt, rsh_r, rsh_nxt;
   logic        txd_r, txd_nxt, rv_r, rv_nxt, rf_r, rf_nxt;

   wire [16:0] bit_len = {1'b0, cfg.div} - 17'd1;
   wire [16:0] stop_len = cfg.stop2 ? {cfg.div, 1'b0} - 17'd1 : bit_len;
   wire        tc_done = (tc_r == '0);
   wire        rc_done = (rc_r == '0);

   assign tx_ready = (ts_r == ST_IDLE) && (!cfg.fc_en || peer_on);
   assign tx_busy  = (ts_r != ST_IDLE);
   assign txd      = txd_r;
   assign rx_data  = rsh_r;
   assign rx_valid = rv_r;
   assign rx_ferr  = rf_r;

   always_comb begin
      ts_nxt  = ts_r;
      tc_nxt  = tc_done ? tc_r : tc_r - 17'd1;
      tb_nxt  = tb_r;
      tsh_nxt = tsh_r;
      txd_nxt = txd_r;
      case (ts_r)
         ST_IDLE: begin
            txd_nxt = 1'b1;
            if (tx_valid && tx_ready) begin
               ts_nxt  = ST_START;
               tc_nxt  = bit_len;
               tsh_nxt = tx_data;
               txd_nxt = 1'b0;
            end
         end
         ST_START: begin
            if (tc_done) begin
               ts_nxt  = ST_BITS;
               tc_nxt  = bit_len;
               tb_nxt  = 3'h0;
               txd_nxt = tsh_r[0];
            end
         end
         ST_BITS: begin
            if (tc_done) begin
               tc_nxt = bit_len;
               if (tb_r == 3'h7) begin
                  ts_nxt  = ST_STOP;
                  tc_nxt  = stop_len;
                  txd_nxt = 1'b1;
               end else begin
                  tb_nxt  = tb_r + 3'h1;
                  tsh_nxt = {1'b0, tsh_r[7:1]};
                  txd_nxt = tsh_r[1];
               end
            end
         end
         ST_STOP: begin
            if (tc_done) begin
               ts_nxt = ST_IDLE;
            end
         end
         default: ts_nxt = ST_IDLE;
      endcase
   end

   always_comb begin
      rs_nxt  = rs_r;
      rc_nxt  = rc_done ? rc_r : rc_r - 17'd1;
      rb_nxt  = rb_r;
      rsh_nxt = rsh_r;
      rv_nxt  = 1'b0;
      rf_nxt  = 1'b0;
      case (rs_r)
         ST_IDLE: begin
            if (!rxd) begin
               rs_nxt = ST_START;
               rc_nxt = {2'b00, cfg.div[15:1]};
            end
         end
         ST_START: begin
            if (rc_done) begin
               // a glitch shorter than half a bit is not a start
               rs_nxt = rxd ? ST_IDLE : ST_BITS;
               rc_nxt = bit_len;
               rb_nxt = 3'h0;
            end
         end
         ST_BITS: begin
            if (rc_done) begin
               rsh_nxt = {rxd, rsh_r[7:1]};
               rc_nxt  = bit_len;
               rb_nxt  = rb_r + 3'h1;
               rs_nxt  = (rb_r == 3'h7) ? ST_STOP : ST_BITS;
            end
         end
         ST_STOP: begin
            if (rc_done) begin
               rs_nxt = ST_IDLE;
               rv_nxt = rxd;
               rf_nxt = !rxd;
            end
         end
         default: rs_nxt = ST_IDLE;
      endcase
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         ts_r  <= ST_IDLE;
         tc_r  <= '0;
         tb_r  <= '0;
         tsh_r <= '0;
         txd_r <= 1'b1;
      end else begin
         ts_r  <= ts_nxt;
         tc_r  <= tc_nxt;
         tb_r  <= tb_nxt;
         tsh_r <= tsh_nxt;
         txd_r <= txd_nxt;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         rs_r  <= ST_IDLE;
         rc_r  <= '0;
         rb_r  <= '0;
         rsh_r <= '0;
         rv_r  <= 1'b0;
         rf_r  <= 1'b0;
      end else begin
         rs_r  <= rs_nxt;
         rc_r  <= rc_nxt;
         rb_r  <= rb_nxt;
         rsh_r <= rsh_nxt;
         rv_r  <= rv_nxt;
         rf_r  <= rf_nxt;
      end
   end

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst);

   property p_fc_hold;
      (ts_r == ST_IDLE && cfg.fc_en && !peer_on) |=> (ts_r == ST_IDLE) && txd_r;
   endproperty
   a_fc_hold: assert property (p_fc_hold) else $error("tx started while peer off");

   property p_frame;
      (ts_r == ST_IDLE && tx_valid && tx_ready) |=> !txd_r ##1 (!txd_r)[*2];
   endproperty
   a_frame: assert property (p_frame) else $error("start bit not low");
endmodule : dum_uart

module dum_top
   import dum_pkg::*;
(
   // clock and reset
   input  wire logic        sys_clk,
   input  wire logic        rst,
   // register port
   input  wire logic [7:0]  reg_addr,
   input  wire logic [31:0] reg_wdata,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   output logic [31:0]      reg_rdata,
   // main port pins, control lines low = ON
   input  wire logic        txd_pin,
   output logic             rxd_pin,
   input  wire logic        rts_n_pin,
   output logic             cts_n_pin,
   // modem pins, shared with the auxiliary port
   input  wire logic        dtr_n_pin,
   input  wire logic        dsr_n_i,
   output logic             dsr_n_o,
   output logic             dsr_oe_n,
   output logic             dcd_n_pin,
   output logic             ri_n_pin
);
   function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
      hit = (a == off);
   endfunction : hit

   // pin synchronisers: txd, rts, dtr, dsr
   wire  [3:0] pin_s;
   wire  [3:0] pin_in = {dsr_n_i, dtr_n_pin, rts_n_pin, txd_pin};
   genvar g;
   generate
      for (g = 0; g < 4; g++) begin : g_sync
         // a flop pair per pin keeps every bit under one driver
         logic s1_r, s2_r;
         assign pin_s[g] = s2_r;
         always_ff @(posedge sys_clk) begin
            if (rst) begin
               s1_r <= 1'b1;
               s2_r <= 1'b1;
            end else begin
               s1_r <= pin_in[g];
               s2_r <= s1_r;
            end
         end
      end
   endgenerate

   logic        aux_en_r, mux_en_r, mfc_r, afc_r, dmode_r;
   logic        dsr_on_r, dcd_on_r, ri_on_r, mstop2_r, astop2_r;
   logic [15:0] mdiv_r, adiv_r;
   logic        mtx_v_r, atx_v_r, arx_v_r, ovr_r, ferr_r, rst_d_r;
   logic [7:0]  mtx_d_r, atx_d_r;
   dum_rxw_t    arx_w_r;
   logic [31:0] rdata_r;
   logic        rxd_r, cts_r, dsr_r, oe_r, dcd_r, ri_r;

   wire w_ctrl = reg_wr && hit(reg_addr, `DUM_A_CTRL);
   wire w_mdat = reg_wr && hit(reg_addr, `DUM_A_MDAT);
   wire w_adat = reg_wr && hit(reg_addr, `DUM_A_ADAT);
   wire r_mdat = reg_rd && hit(reg_addr, `DUM_A_MDAT);
   wire r_adat = reg_rd && hit(reg_addr, `DUM_A_ADAT);
   wire r_stat = reg_rd && hit(reg_addr, `DUM_A_STAT);
   wire aux_on = w_ctrl && reg_wdata[`DUM_C_AUX] && !aux_en_r;

   // engines
   logic     m_txd, m_tx_rdy, m_busy, m_rxv, m_ferr;
   logic     a_txd, a_tx_rdy, a_busy, a_rxv, a_ferr;
   logic [7:0] m_rxd, a_rxd;
   dum_cfg_t m_cfg, a_cfg;
   assign m_cfg = '{div: mdiv_r, stop2: mstop2_r, fc_en: mfc_r};
   assign a_cfg = '{div: adiv_r, stop2: astop2_r, fc_en: afc_r};

   wire rts_on  = !pin_s[1];
   wire a_rx_in = aux_en_r ? pin_s[2] : 1'b1;
   wire a_peer  = aux_en_r && !pin_s[3];

   dum_uart u_main (
      .sys_clk (sys_clk),   .rst      (rst),      .cfg     (m_cfg),
      .tx_data (mtx_d_r),   .tx_valid (mtx_v_r),  .tx_ready(m_tx_rdy),
      .tx_busy (m_busy),    .peer_on  (rts_on),   .txd     (m_txd),
      .rxd     (pin_s[0]),  .rx_data  (m_rxd),    .rx_valid(m_rxv),
      .rx_ferr (m_ferr)
   );

   dum_uart u_aux (
      .sys_clk (sys_clk),   .rst      (rst),      .cfg     (a_cfg),
      .tx_data (atx_d_r),   .tx_valid (atx_v_r && aux_en_r),
      .tx_ready(a_tx_rdy),  .tx_busy  (a_busy),   .peer_on (a_peer),
      .txd     (a_txd),     .rxd      (a_rx_in),  .rx_data (a_rxd),
      .rx_valid(a_rxv),     .rx_ferr  (a_ferr)
   );

   // main receive path: tag then buffer
   dum_rxw_t m_rxw, f_out;
   logic     f_in_rdy, f_out_v;
   wire      f_pop = r_mdat && f_out_v;
   assign m_rxw = '{tag:  mux_en_r ? TAG_MUX : (dmode_r ? TAG_DATA : TAG_CMD),
                    data: m_rxd};

   dum_fifo #(.W($bits(dum_rxw_t)), .D(`DUM_FIFO_DEPTH)) u_fifo (
      .sys_clk  (sys_clk),
      .rst      (rst),
      .in_data  (m_rxw),
      .in_valid (m_rxv),
      .in_ready (f_in_rdy),
      .out_data (f_out),
      .out_valid(f_out_v),
      .out_ready(f_pop)
   );

   // multiplexing never applies to the auxiliary port
   dum_rxw_t a_rxw;
   assign a_rxw = '{tag: dmode_r ? TAG_DATA : TAG_CMD, data: a_rxd};

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         aux_en_r <= 1'b0;
         mux_en_r <= 1'b0;
         mfc_r    <= 1'b1;
         dmode_r  <= 1'b0;
         mstop2_r <= 1'b0;
         dsr_on_r <= 1'b0;
         dcd_on_r <= 1'b0;
         ri_on_r  <= 1'b0;
      end else if (w_ctrl) begin
         aux_en_r <= reg_wdata[`DUM_C_AUX];
         mux_en_r <= reg_wdata[`DUM_C_MUX];
         mfc_r    <= reg_wdata[`DUM_C_MFC];
         dmode_r  <= reg_wdata[`DUM_C_DATA];
         mstop2_r <= reg_wdata[`DUM_C_MSTOP2];
         dsr_on_r <= reg_wdata[`DUM_C_DSR];
         dcd_on_r <= reg_wdata[`DUM_C_DCD];
         ri_on_r  <= reg_wdata[`DUM_C_RI];
      end
   end

   // enabling the aux port forces its defaults over the written bits
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         afc_r    <= 1'b1;
         astop2_r <= 1'b0;
         adiv_r   <= `DUM_DIV_DEF;
      end else if (aux_on) begin
         afc_r    <= 1'b1;
         astop2_r <= 1'b0;
         adiv_r   <= `DUM_DIV_DEF;
      end else begin
         afc_r    <= w_ctrl ? reg_wdata[`DUM_C_AFC] : afc_r;
         astop2_r <= w_ctrl ? reg_wdata[`DUM_C_ASTOP2] : astop2_r;
         if (reg_wr && hit(reg_addr, `DUM_A_ADIV)) begin
            adiv_r <= reg_wdata[15:0];
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         mdiv_r <= `DUM_DIV_DEF;
      end else if (reg_wr && hit(reg_addr, `DUM_A_MDIV)) begin
         mdiv_r <= reg_wdata[15:0];
      end
   end

   // tx holding registers; a write while full is dropped
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         mtx_v_r <= 1'b0;
         atx_v_r <= 1'b0;
         mtx_d_r <= '0;
         atx_d_r <= '0;
      end else begin
         mtx_v_r <= (w_mdat && !mtx_v_r) || (mtx_v_r && !m_tx_rdy);
         atx_v_r <= (w_adat && !atx_v_r) || (atx_v_r && !(a_tx_rdy && aux_en_r));
         mtx_d_r <= (w_mdat && !mtx_v_r) ? reg_wdata[7:0] : mtx_d_r;
         atx_d_r <= (w_adat && !atx_v_r) ? reg_wdata[7:0] : atx_d_r;
      end
   end

   // aux receive holding register
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         arx_v_r <= 1'b0;
         arx_w_r <= '0;
      end else begin
         arx_v_r <= a_rxv || (arx_v_r && !r_adat);
         arx_w_r <= a_rxv ? a_rxw : arx_w_r;
      end
   end

   // sticky errors: a new event wins over the clearing status read
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         ovr_r  <= 1'b0;
         ferr_r <= 1'b0;
         rst_d_r <= 1'b1;
      end else begin
         ovr_r  <= (m_rxv && !f_in_rdy) || (a_rxv && arx_v_r) || (ovr_r && !r_stat);
         ferr_r <= m_ferr || a_ferr || (ferr_r && !r_stat);
         rst_d_r <= 1'b0;
      end
   end

   // read data, valid only in the cycle after the strobe
   wire [31:0] stat_w = {24'h0, ferr_r, ovr_r, rts_on, !pin_s[2] && !aux_en_r,
                         a_busy, arx_v_r, m_busy, f_out_v};
   wire [31:0] ctrl_w = {22'h0, astop2_r, mstop2_r, dmode_r, ri_on_r, dcd_on_r,
                         dsr_on_r, afc_r, mfc_r, mux_en_r, aux_en_r};
   wire [31:0] rd_mux =
      hit(reg_addr, `DUM_A_CTRL) ? ctrl_w :
      hit(reg_addr, `DUM_A_MDIV) ? {16'h0, mdiv_r} :
      hit(reg_addr, `DUM_A_ADIV) ? {16'h0, adiv_r} :
      hit(reg_addr, `DUM_A_MDAT) ? {21'h0, f_out_v, f_out} :
      hit(reg_addr, `DUM_A_ADAT) ? {21'h0, arx_v_r, arx_w_r} :
      hit(reg_addr, `DUM_A_STAT) ? stat_w : 32'h0;

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         rdata_r <= '0;
      end else begin
         rdata_r <= reg_rd ? rd_mux : 32'h0;
      end
   end
   assign reg_rdata = rdata_r;

   // pin roles; the aux port owns the modem pins exclusively
   wire cts_nxt = mfc_r && !f_in_rdy;
   wire dcd_nxt = aux_en_r ? a_txd : !dcd_on_r;
   wire ri_nxt  = aux_en_r ? (afc_r && arx_v_r) : !ri_on_r;

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         rxd_r <= 1'b1;
         cts_r <= 1'b0;
         dsr_r <= 1'b1;
         oe_r  <= 1'b0;
         dcd_r <= 1'b1;
         ri_r  <= 1'b1;
      end else begin
         rxd_r <= m_txd;
         cts_r <= cts_nxt;
         dsr_r <= !dsr_on_r;
         oe_r  <= aux_en_r;
         dcd_r <= dcd_nxt;
         ri_r  <= ri_nxt;
      end
   end

   assign rxd_pin   = rxd_r;
   assign cts_n_pin = cts_r;
   assign dsr_n_o   = dsr_r;
   assign dsr_oe_n  = oe_r;
   assign dcd_n_pin = dcd_r;
   assign ri_n_pin  = ri_r;

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst);

   property p_defaults;
      rst_d_r |-> mfc_r && !mux_en_r && !aux_en_r && !dmode_r && !mstop2_r
                  && (mdiv_r == `DUM_DIV_DEF);
   endproperty
   a_defaults: assert property (p_defaults) else $error("bad power-up defaults");

   property p_cmd_tag;
      (m_rxv && !dmode_r && !mux_en_r) |-> (m_rxw.tag == TAG_CMD);
   endproperty
   a_cmd_tag: assert property (p_cmd_tag) else $error("command mode tag wrong");

   property p_mux_explicit;
      $rose(mux_en_r) |-> $past(w_ctrl && reg_wdata[`DUM_C_MUX]);
   endproperty
   a_mux_explicit: assert property (p_mux_explicit) else $error("mux on unasked");

   property p_aux_owns;
      (aux_en_r && $past(aux_en_r)) |-> dsr_oe_n ##1 (!aux_en_r || dsr_oe_n);
   endproperty
   a_aux_owns: assert property (p_aux_owns) else $error("dsr driven in aux mode");

   property p_aux_defaults;
      $rose(aux_en_r) |-> afc_r && !astop2_r && (adiv_r == `DUM_DIV_DEF);
   endproperty
   a_aux_defaults: assert property (p_aux_defaults) else $error("aux defaults lost");

   property p_aux_data;
      (aux_en_r && $past(aux_en_r)) |-> (dcd_n_pin == $past(a_txd));
   endproperty
   a_aux_data: assert property (p_aux_data) else $error("dcd not aux data");

   property p_no_aux_mux;
      arx_v_r |-> (arx_w_r.tag != TAG_MUX);
   endproperty
   a_no_aux_mux: assert property (p_no_aux_mux) else $error("mux tag on aux");

   property p_flow_off;
      (mfc_r && !f_in_rdy) |=> cts_n_pin;
   endproperty
   a_flow_off: assert property (p_flow_off) else $error("cts on with full buffer");

   property p_mux_tag;
      (m_rxv && mux_en_r && !f_out_v) |=> (f_out.tag == TAG_MUX);
   endproperty
   a_mux_tag: assert property (p_mux_tag) else $error("mux frame not tagged");
endmodule : dum_top

// ### logic/dum_defs.svh
/*
 Constants of the dual modem serial port: clock and baud defaults,
 register byte offsets, control and status field positions, reset values.
 Assumes a 50 MHz system clock and inclusion by its bare name.
*/
`ifndef DUM_DEFS_SVH
`define DUM_DEFS_SVH

`define DUM_CLK_HZ      50000000
`define DUM_BAUD_DEF    115200
`define DUM_DIV_DEF     (16'(`DUM_CLK_HZ / `DUM_BAUD_DEF))
`define DUM_FIFO_DEPTH  16

`define DUM_A_CTRL      8'h00
`define DUM_A_MDIV      8'h04
`define DUM_A_ADIV      8'h08
`define DUM_A_MDAT      8'h0c
`define DUM_A_ADAT      8'h10
`define DUM_A_STAT      8'h14

`define DUM_C_AUX       0
`define DUM_C_MUX       1
`define DUM_C_MFC       2
`define DUM_C_AFC       3
`define DUM_C_DSR       4
`define DUM_C_DCD       5
`define DUM_C_RI        6
`define DUM_C_DATA      7
`define DUM_C_MSTOP2    8
`define DUM_C_ASTOP2    9

`define DUM_S_MRX       0
`define DUM_S_MTX       1
`define DUM_S_ARX       2
`define DUM_S_ATX       3
`define DUM_S_DTR       4
`define DUM_S_RTS       5
`define DUM_S_OVR       6
`define DUM_S_FERR      7

`define DUM_D_VALID     10

`endif

// ### logic/dum_pkg.sv
/*
 Types of the dual modem serial port: engine states, receive tags,
 the received-word carrier and the per-port line configuration.
 Assumes nothing beyond a SystemVerilog compiler.
*/
package dum_pkg;

   typedef enum logic [1:0] {
      ST_IDLE  = 2'b00,
      ST_START = 2'b01,
      ST_BITS  = 2'b10,
      ST_STOP  = 2'b11
   } dum_st_t;

   typedef enum logic [1:0] {
      TAG_CMD  = 2'b00,
      TAG_DATA = 2'b01,
      TAG_MUX  = 2'b10
   } dum_tag_t;

   typedef struct packed {
      dum_tag_t   tag;
      logic [7:0] data;
   } dum_rxw_t;

   typedef struct packed {
      logic [15:0] div;
      logic        stop2;
      logic        fc_en;
   } dum_cfg_t;

endpackage : dum_pkg

// ### test/dum_host.sv
/*
 Host-side serial model: one data line each way plus a flow pair.
 Assumes sys_clk from the bench and div set before any traffic.
*/
`timescale 1ns/1ps
module dum_host (
   // clock
   input  wire logic sys_clk,
   // lines from the module
   input  wire logic line_in,
   input  wire logic peer_flow_n,
   // lines to the module
   output logic      line_out,
   output logic      flow_n
);
   int   div  = 434;
   logic hold = 1'b0;

   initial line_out = 1'b1;
   assign flow_n = hold;

   task automatic send(input logic [7:0] b, output logic ok);
      int         n;
      logic [9:0] fr;
      fr = {1'b1, b, 1'b0};
      n  = 0;
      @(posedge sys_clk);
      while (peer_flow_n && n < 5000) begin
         @(posedge sys_clk);
         n++;
      end
      ok = (n < 5000);
      for (int i = 0; i < 10; i++) begin
         line_out <= fr[i];
         repeat (div) @(posedge sys_clk);
      end
   endtask : send

   task automatic recv(output logic [7:0] b, output logic ok);
      int n;
      n = 0;
      b = 8'h00;
      // falling edge sampling stays clear of the pin register updates
      while (line_in && n < 5000) begin
         @(negedge sys_clk);
         n++;
      end
      // mid-bit sampling tolerates the output register lag
      repeat (div / 2) @(negedge sys_clk);
      ok = (n < 5000) && !line_in;
      for (int i = 0; i < 8; i++) begin
         repeat (div) @(negedge sys_clk);
         b[i] = line_in;
      end
      repeat (div) @(negedge sys_clk);
      ok = ok && line_in;
   endtask : recv
endmodule : dum_host

// ### test/dum_top_tb_top.sv
/*
 Bench of the dual modem serial port: register tasks and host models.
 Assumes the design files and defines header are compiled first.
*/
`timescale 1ns/1ps
`include "dum_defs.svh"
module dum_top_tb_top;
   logic        sys_clk, rst, reg_wr, reg_rd;
   logic [7:0]  reg_addr;
   logic [31:0] reg_wdata, reg_rdata;
   logic        txd_pin, rxd_pin, rts_n_pin, cts_n_pin, dtr_n_pin;
   logic        dsr_n_i, dsr_n_o, dsr_oe_n, dcd_n_pin, ri_n_pin, host_dsr_n;
   int          errors, samples_checked;

   assign dsr_n_i = dsr_oe_n ? host_dsr_n : dsr_n_o;

   dum_top u_dut (.sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .txd_pin(txd_pin), .rxd_pin(rxd_pin), .rts_n_pin(rts_n_pin), .cts_n_pin(cts_n_pin),
      .dtr_n_pin(dtr_n_pin), .dsr_n_i(dsr_n_i), .dsr_n_o(dsr_n_o), .dsr_oe_n(dsr_oe_n),
      .dcd_n_pin(dcd_n_pin), .ri_n_pin(ri_n_pin));
   dum_host u_hm (.sys_clk(sys_clk), .line_in(rxd_pin), .peer_flow_n(cts_n_pin),
      .line_out(txd_pin), .flow_n(rts_n_pin));
   dum_host u_ha (.sys_clk(sys_clk), .line_in(dcd_n_pin), .peer_flow_n(ri_n_pin),
      .line_out(dtr_n_pin), .flow_n(host_dsr_n));

   initial begin
      sys_clk = 1'b0;
      forever #10 sys_clk = ~sys_clk;
   end

   task automatic stop_test();
      $display("checks %0d errors %0d", samples_checked, errors);
      if (errors == 0 && samples_checked > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : stop_test

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         errors++;
         $display("ERROR %0t saw %h expected %h", $time, seen, exp);
      end
   endtask : chk

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge sys_clk);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_wr    <= 1'b1;
      @(posedge sys_clk);
      reg_wr <= 1'b0;
   endtask : wr

   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge sys_clk);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(posedge sys_clk);
      reg_rd <= 1'b0;
      #1 d = reg_rdata;
   endtask : rd

   task automatic wait_rx(input int k);
      logic [31:0] s;
      s = 32'h0;
      for (int n = 0; n < 100 && !s[k]; n++) rd(`DUM_A_STAT, s);
      if (!s[k]) begin
         errors++;
         $display("ERROR %0t no character arrived", $time);
         stop_test();
      end
   endtask : wait_rx

   task automatic endt(input string name);
      $display("test %s finished", name);
   endtask : endt

   initial begin
      repeat (100000) @(posedge sys_clk);
      errors++;
      stop_test();
   end

   initial begin : main
      logic [31:0] d;
      logic [7:0]  b;
      logic        ok;
      errors = 0;
      samples_checked = 0;
      rst = 1'b1;
      reg_addr = 8'h00;
      reg_wdata = 32'h0;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      repeat (5) @(posedge sys_clk);
      rst <= 1'b0;
      #1 chk(32'({rxd_pin, cts_n_pin, dsr_n_o, dsr_oe_n, dcd_n_pin, ri_n_pin}), 32'h2b);
      rd(`DUM_A_CTRL, d);
      chk(d, 32'h00c);
      rd(`DUM_A_MDIV, d);
      chk(d, 32'h1b2);
      rd(`DUM_A_ADIV, d);
      chk(d, 32'h1b2);
      rd(8'h20, d);
      chk(d, 32'h0);
      endt("defaults");
      // one character at the full default rate and frame
      u_hm.send(8'h5a, ok);
      chk(32'(ok), 32'h1);
      wait_rx(`DUM_S_MRX);
      rd(`DUM_A_MDAT, d);
      chk(d, 32'h45a);
      wr(`DUM_A_MDIV, 32'h8);
      u_hm.div = 8;
      wr(`DUM_A_CTRL, 32'h07c);
      repeat (2) @(posedge sys_clk);
      chk(32'({dsr_n_o, dsr_oe_n, dcd_n_pin, ri_n_pin}), 32'h0);
      u_ha.line_out <= 1'b0;
      repeat (4) @(posedge sys_clk);
      rd(`DUM_A_STAT, d);
      chk(d, 32'h030);
      u_ha.line_out <= 1'b1;
      wr(`DUM_A_CTRL, 32'h10c);
      endt("modem lines");
      u_hm.hold <= 1'b1;
      wr(`DUM_A_MDAT, 32'ha5);
      repeat (40) @(posedge sys_clk);
      chk(32'(rxd_pin), 32'h1);
      fork
         u_hm.recv(b, ok);
         begin
            repeat (2) @(posedge sys_clk);
            u_hm.hold <= 1'b0;
         end
      join
      chk(32'({ok, b}), 32'h1a5);
      endt("main transmit");
      for (int i = 0; i < 16; i++) begin
         u_hm.send(8'h30 + 8'(i), ok);
         chk(32'(ok), 32'h1);
      end
      repeat (40) @(posedge sys_clk);
      chk(32'(cts_n_pin), 32'h1);
      for (int i = 0; i < 16; i++) begin
         rd(`DUM_A_MDAT, d);
         chk(d, 32'h430 + 32'(i));
      end
      rd(`DUM_A_MDAT, d);
      chk(32'(d[`DUM_D_VALID]), 32'h0);
      chk(32'(cts_n_pin), 32'h0);
      endt("fifo fill");
      wr(`DUM_A_CTRL, 32'h00e);
      u_hm.send(8'h6b, ok);
      chk(32'(ok), 32'h1);
      wait_rx(`DUM_S_MRX);
      rd(`DUM_A_MDAT, d);
      chk(d, 32'h66b);
      wr(`DUM_A_ADIV, 32'h8);
      wr(`DUM_A_CTRL, 32'h287);
      rd(`DUM_A_CTRL, d);
      chk(d, 32'h08f);
      rd(`DUM_A_ADIV, d);
      chk(d, 32'h1b2);
      chk(32'(dsr_oe_n), 32'h1);
      wr(`DUM_A_ADIV, 32'h8);
      u_ha.div = 8;
      u_ha.send(8'h3c, ok);
      chk(32'(ok), 32'h1);
      wait_rx(`DUM_S_ARX);
      rd(`DUM_A_ADAT, d);
      chk(d, 32'h53c);
      fork
         u_ha.recv(b, ok);
         wr(`DUM_A_ADAT, 32'hc3);
      join
      chk(32'({ok, b}), 32'h1c3);
      endt("auxiliary port");
      stop_test();
   end
endmodule : dum_top_tb_top
